// ===== tb.sv
// self-checking bench for the capture/compare timer
`timescale 1ns/1ps
`default_nettype none
module tb import ttcc_pkg::*;;
	logic              clk;
	logic              rst;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata;
	logic [31:0]       prdata;
	logic [31:0]       rd;
	logic              pready;
	logic              pslverr;
	logic              err;
	logic              ti0;
	logic              ti1;
	logic              pin;
	logic              pin_oe;
	logic [7:0]        port0_oe;
	logic              irq0;
	logic              irq1;
	int                fails = 0;
	int                tests_run = 0;
	int                cyc = 0;
	int                n0 = 0;
	int                n1 = 0;

	// capture cases: select bits are {toggled input, watched request}
	localparam logic [7:0] CP_PRM [11] = '{8'h00, 8'h40, 8'hC0, 8'h00, 8'h10, 8'h30,
		8'h00, 8'h10, 8'h10, 8'h30, 8'h42};
	localparam logic [7:0] CP_CRC [11] = '{8'h01, 8'h01, 8'h01, 8'h00, 8'h04, 8'h04,
		8'h04, 8'h00, 8'h03, 8'h03, 8'h01};
	localparam logic [1:0] CP_SEL [11] = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h1, 2'h1,
		2'h1, 2'h1, 2'h0, 2'h0, 2'h2};
	localparam logic [15:0] RV_IDX [5] = '{IDX_PORT0_DIR, IDX_TMC, IDX_PRM, IDX_CRC, IDX_TOC};
	localparam logic [7:0]  RV_VAL [5] = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};

	ttcc_timer #(.CNT_W(16)) u_ttcc_timer (
		.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .trigger_input_0(ti0), .trigger_input_1(ti1),
		.timer_output_pin(pin), .timer_output_oe(pin_oe), .port0_oe(port0_oe),
		.match0_interrupt(irq0), .match1_interrupt(irq1)
	);

	ttcc_trig_model u_ttcc_trig_model (
		.clk(clk), .trigger_input_0(ti0), .trigger_input_1(ti1)
	);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (irq0 === 1'b1) n0 <= n0 + 1;
		if (irq1 === 1'b1) n1 <= n1 + 1;
	end

	task automatic conclude();
		if (fails == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// count clock period in system clocks; zero for the edge-count setting
	function automatic int div_of(input logic [1:0] cs);
		unique case (cs)
			CLK_DIV2:   div_of = 2;
			CLK_DIV16:  div_of = 16;
			CLK_DIV128: div_of = 128;
			default:    div_of = 0;
		endcase
	endfunction

	// requests expected from one pulse on the chosen pin
	function automatic int caps_exp(input logic [7:0] prm, input logic [7:0] crc,
		input logic [1:0] sel, input int len);
		logic [1:0] es;
		int         k;
		es = sel[1] ? prm[PRM_E1_LO +: 2] : prm[PRM_E0_LO +: 2];
		k = (es == EDGE_BOTH) ? 2 : 1;
		if (len <= div_of(prm[PRM_CLK_LO +: 2])) begin
			// never two equal samples inside the pulse
			caps_exp = 0;
		end else if (sel[1]) begin
			caps_exp = (crc[CRC_R0_CAP] && !crc[CRC_R0_TRIG]) ? k : 0;
		end else if (sel[0]) begin
			caps_exp = crc[CRC_R1_CAP] ? k : 0;
		end else begin
			caps_exp = (crc[CRC_R0_CAP] && crc[CRC_R0_TRIG] && es != EDGE_BOTH) ? 1 : 0;
		end
	endfunction

	// one apb transfer; held until pready is seen at a rising edge
	task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		check({31'h0, k < 50}, 32'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wpin(input logic [7:0] toc, input logic exp);
		apb(1'b1, IDX_TOC, {24'h0, toc});
		repeat (3) @(posedge clk);
		check({31'h0, pin}, {31'h0, exp});
	endtask

	task automatic wait_ev(input bit ch, output int st);
		int base;
		int k;
		base = ch ? n1 : n0;
		k = 0;
		while ((ch ? n1 : n0) == base && k < 3000) begin
			@(posedge clk);
			k++;
		end
		check({31'h0, k < 3000}, 32'h1);
		st = cyc;
	endtask

	task automatic interval(input logic [1:0] cs, input logic [7:0] toc, input bit ch);
		int s1;
		int s2;
		logic p1;
		logic [15:0] n;
		n = 16'($urandom_range(2, 9));
		apb(1'b1, IDX_TMC, 32'h0);
		apb(1'b0, IDX_COUNT, 32'h0);
		check(rd, 32'h0);
		apb(1'b1, IDX_CRC, 32'h0);
		apb(1'b1, IDX_TOC, {24'h0, toc});
		apb(1'b1, IDX_PRM, {30'h0, cs});
		apb(1'b1, IDX_CAPCOMP0, {16'h0, n});
		apb(1'b1, IDX_CAPCOMP1, {17'h0, n[15:1]});
		apb(1'b1, IDX_TMC, 32'h0000000C);
		wait_ev(ch, s1);
		wait_ev(ch, s1);
		repeat (3) @(posedge clk);
		p1 = pin;
		wait_ev(ch, s2);
		repeat (3) @(posedge clk);
		check(32'(s2 - s1), 32'((int'(n) + 1) * div_of(cs)));
		check({31'h0, pin}, {31'h0, ~p1});
	endtask

	initial begin
		int base;
		int len;
		int m;
		int ex;
		logic p0;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		void'($urandom(32'hCE750DC1));
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, RV_IDX[i], 32'h0);
			check(rd, {24'h0, RV_VAL[i]});
		end
		check({24'h0, port0_oe}, 32'h0);
		apb(1'b0, 16'h0100, 32'h0);
		check({31'h0, err}, 32'h1);
		check(rd, 32'h0);
		apb(1'b1, IDX_PORT0_DIR, 32'h000000DF);
		repeat (3) @(posedge clk);
		check({24'h0, port0_oe}, 32'h20);
		check({31'h0, pin_oe}, 32'h1);
		wpin(8'h09, 1'b1);
		apb(1'b0, IDX_TOC, 32'h0);
		check(rd, 32'h1);
		wpin(8'h05, 1'b0);
		wpin(8'h08, 1'b0);
		// port mode: the latch bit reaches the pin
		apb(1'b1, IDX_PORT0_LAT, 32'h00000020);
		wpin(8'h00, 1'b1);
		apb(1'b1, IDX_PORT0_LAT, 32'h0);
		wpin(8'h01, 1'b1);
		interval(CLK_DIV2, 8'h03, 1'b0);
		interval(CLK_DIV16, 8'h11, 1'b1);
		interval(CLK_DIV128, 8'h03, 1'b0);
		for (int i = 0; i < 11; i++) begin
			apb(1'b1, IDX_TMC, 32'h0);
			apb(1'b1, IDX_CAPCOMP0, 32'h0000FFFF);
			apb(1'b1, IDX_CAPCOMP1, 32'h0000FFFF);
			apb(1'b1, IDX_CRC, {24'h0, CP_CRC[i]});
			apb(1'b1, IDX_PRM, {24'h0, CP_PRM[i]});
			apb(1'b1, IDX_TMC, 32'h00000004);
			repeat (10) @(posedge clk);
			base = CP_SEL[i][0] ? n1 : n0;
			// last case: pulse far shorter than two div128 samples
			len = (i == 10) ? 20 : 10 + $urandom_range(0, 6);
			u_ttcc_trig_model.pulse(CP_SEL[i][1], len);
			ex = caps_exp(CP_PRM[i], CP_CRC[i], CP_SEL[i], len);
			repeat (40) @(posedge clk);
			check(32'((CP_SEL[i][0] ? n1 : n0) - base), 32'(ex));
			apb(1'b0, CP_SEL[i][0] ? IDX_CAPCOMP1 : IDX_CAPCOMP0, 32'h0);
			check({31'h0, rd[15:0] !== 16'hFFFF}, {31'h0, ex != 0});
		end
		// count input 0 rising edges; output timing bit flips the flop per edge
		apb(1'b1, IDX_TMC, 32'h0);
		apb(1'b1, IDX_CRC, 32'h0);
		apb(1'b1, IDX_TOC, 32'h00000001);
		apb(1'b1, IDX_PRM, 32'h00000013);
		apb(1'b1, IDX_TMC, 32'h00000006);
		m = $urandom_range(3, 6);
		repeat (3) @(posedge clk);
		p0 = pin;
		for (int j = 0; j < m; j++) begin
			u_ttcc_trig_model.pulse(1'b0, 6);
		end
		apb(1'b0, IDX_COUNT, 32'h0);
		check(rd, 32'(m));
		check({31'h0, pin}, {31'h0, p0 ^ m[0]});
		// count runs from the mode write; input 0 rising edge clears it
		apb(1'b1, IDX_TMC, 32'h0);
		apb(1'b1, IDX_PRM, 32'h00000010);
		apb(1'b1, IDX_TMC, 32'h00000008);
		repeat (300) @(posedge clk);
		apb(1'b0, IDX_COUNT, 32'h0);
		check({31'h0, rd[15:0] > 16'h0040}, 32'h1);
		u_ttcc_trig_model.pulse(1'b0, 8);
		apb(1'b0, IDX_COUNT, 32'h0);
		check({31'h0, rd[15:0] < 16'h0020}, 32'h1);
		// second reset in mid-run brings back the defaults
		@(posedge clk);
		rst <= 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, IDX_PORT0_DIR, 32'h0);
		check(rd, 32'h000000FF);
		check({24'h0, port0_oe}, 32'h0);
		check({31'h0, pin_oe}, 32'h0);
		apb(1'b0, IDX_COUNT, 32'h0);
		check(rd, 32'h0);
		conclude();
	end

	// whole run is at most about 7k cycles
	initial begin
		repeat (60000) @(posedge clk);
		fails++;
		conclude();
	end
endmodule
`default_nettype wire

// ===== ttcc_pkg.sv
// constants, register map and mode type of the 16-bit capture/compare timer
//
// How it works
// - compare-0 clear mode with compare 0 all ones sets overflow on wrap
// - register 1 compares when its mode bit is 0, captures when 1
// - register 0 captures on input 1 edge, or on reverse input 0 edge
// - register 0 compares when its mode bit is 0, captures when 1
// - both-edge input 0 with reverse-phase select gives no register 0 capture
// - compare-1 inversion bit toggles output flop on count equal register 1
// - set/reset pair: 00 keep, 01 clear, 10 set output flop
// - compare-0 inversion bit toggles output flop on count equal register 0
// - output enable 0 leaves pin in port mode, 1 drives flop out
// - output set and reset bits always read back as zero
// - input 1 edge field: 00 falling, 01 rising, 11 both
// - input 0 edge field: 00 falling, 01 rising, 11 both
// - count clock: divide by 2, 16, 128, or input 0 valid edges
// - direction bit 0 means output, 1 input; resets to all ones
// - interval mode: match clears count, keeps counting, raises match 0 request
// - both mode bits zero stop the counter and hold it at zero
// - compare-mode register 1 match raises the match 1 request
// - trigger edges sampled on count clock (/2 in edge-count mode), need two equal samples
package ttcc_pkg;

	localparam int ADDR_W = 18;

	// register indexes; byte address is four times the index
	localparam logic [15:0] IDX_PORT0_DIR  = 16'hFF20;
	localparam logic [15:0] IDX_PORT0_LAT  = 16'hFF00;
	localparam logic [15:0] IDX_TMC        = 16'hFF60;
	localparam logic [15:0] IDX_PRM        = 16'hFF61;
	localparam logic [15:0] IDX_CRC        = 16'hFF62;
	localparam logic [15:0] IDX_TOC        = 16'hFF63;
	localparam logic [15:0] IDX_COUNT      = 16'hFF10;
	localparam logic [15:0] IDX_CAPCOMP0   = 16'hFF12;
	localparam logic [15:0] IDX_CAPCOMP1   = 16'hFF14;

	localparam logic [7:0] RST_PORT0_DIR  = 8'hFF;
	localparam logic [7:0] RST_PORT0_LAT  = 8'h00;
	localparam logic [7:0] RST_CTRL       = 8'h00;

	// field positions
	localparam int TMC_OVF      = 0;
	localparam int TMC_OUT_TIME = 1;
	localparam int TMC_MODE_LO  = 2;
	localparam int CRC_R0_CAP   = 0;
	localparam int CRC_R0_TRIG  = 1;
	localparam int CRC_R1_CAP   = 2;
	localparam int TOC_OE       = 0;
	localparam int TOC_INV0     = 1;
	localparam int TOC_RESET    = 2;
	localparam int TOC_SET      = 3;
	localparam int TOC_INV1     = 4;
	localparam int PRM_CLK_LO   = 0;
	localparam int PRM_E0_LO    = 4;
	localparam int PRM_E1_LO    = 6;
	localparam int SHARED_PIN   = 5;

	// writable bit masks
	localparam logic [7:0] TMC_MASK = 8'h0F;
	localparam logic [7:0] CRC_MASK = 8'h07;
	localparam logic [7:0] TOC_MASK = 8'h13;
	localparam logic [7:0] PRM_MASK = 8'hF3;

	// prescaler: 7-bit divider gives /2, /16, /128
	localparam int PRE_W = 7;

	// edge field encodings
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h3;

	localparam logic [1:0] CLK_DIV2   = 2'h0;
	localparam logic [1:0] CLK_DIV16  = 2'h1;
	localparam logic [1:0] CLK_DIV128 = 2'h2;
	localparam logic [1:0] CLK_EDGE   = 2'h3;

	typedef enum logic [1:0] {
		MODE_STOP,
		MODE_FREE,
		MODE_CLR_EDGE,
		MODE_CLR_MATCH
	} ttcc_mode_t;

endpackage

// ===== ttcc_timer.sv
// 16-bit capture/compare timer with apb register access
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module ttcc_timer import ttcc_pkg::*; #(
	parameter int CNT_W = 16
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              trigger_input_0,
	input  wire logic              trigger_input_1,
	output logic                   timer_output_pin,
	output logic                   timer_output_oe,
	output logic      [7:0]        port0_oe,
	output logic                   match0_interrupt,
	output logic                   match1_interrupt
);
	generate
		if (CNT_W != 16) begin : g_bad_width
			$error("count width must be 16");
		end
	endgenerate

	function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
		unique case (sel)
			EDGE_FALL: edge_hit = f;
			EDGE_RISE: edge_hit = r;
			EDGE_BOTH: edge_hit = r | f;
			default:   edge_hit = 1'b0;
		endcase
	endfunction

	function automatic logic div_tick(input logic [PRE_W-1:0] pre, input logic [1:0] sel);
		unique case (sel)
			CLK_DIV2:   div_tick = pre[0];
			CLK_DIV16:  div_tick = &pre[3:0];
			CLK_DIV128: div_tick = &pre;
			default:    div_tick = pre[0];
		endcase
	endfunction

	logic [7:0]       dir_r, lat_r, tmc_r, prm_r, crc_r, toc_r;
	logic [7:0]       dir_nxt, lat_nxt, tmc_nxt, prm_nxt, crc_nxt, toc_nxt;
	logic [CNT_W-1:0] cnt_r, cr0_r, cr1_r, cnt_nxt, cr0_nxt, cr1_nxt;
	logic [PRE_W-1:0] pre_r, pre_nxt;
	logic             tff_r, tff_nxt, irq0_r, irq0_nxt, irq1_r, irq1_nxt;
	logic             pin_r, pin_nxt, pin_oe_r, pin_oe_nxt;
	logic [7:0]       poe_r, poe_nxt;
	logic [31:0]      rdata_r, rdata_nxt;
	logic             ready_r, ready_nxt, err_r, err_nxt;

	logic [1:0]  rise, fall;
	logic        samp, tick, running, e0_valid, e0_rev, e1_valid;
	logic        m0, m1, cap0, cap1, ovf_set, tgl, wr, acc, hit;
	logic [15:0] idx;
	ttcc_mode_t  mode;

	// input 0 edges are the count clock in edge mode, so filter at /2 then
	assign samp = div_tick(pre_r, (prm_r[PRM_CLK_LO +: 2] == CLK_EDGE) ? CLK_DIV2
		: prm_r[PRM_CLK_LO +: 2]);

	generate
		for (genvar i = 0; i < 2; i++) begin : g_trig
			ttcc_trig_filter u_filt (
				.clk    (clk),
				.rst    (rst),
				.pin_in ((i == 0) ? trigger_input_0 : trigger_input_1),
				.sample (samp),
				.rise   (rise[i]),
				.fall   (fall[i])
			);
		end
	endgenerate

	always_comb begin
		mode     = ttcc_mode_t'(tmc_r[TMC_MODE_LO +: 2]);
		running  = (mode != MODE_STOP);
		e0_valid = edge_hit(prm_r[PRM_E0_LO +: 2], rise[0], fall[0]);
		e1_valid = edge_hit(prm_r[PRM_E1_LO +: 2], rise[1], fall[1]);
		unique case (prm_r[PRM_E0_LO +: 2])
			EDGE_FALL: e0_rev = rise[0];
			EDGE_RISE: e0_rev = fall[0];
			default:   e0_rev = 1'b0;
		endcase
		tick = (prm_r[PRM_CLK_LO +: 2] == CLK_EDGE) ? e0_valid
			: div_tick(pre_r, prm_r[PRM_CLK_LO +: 2]);
		m0   = running && tick && !crc_r[CRC_R0_CAP] && cnt_r == cr0_r;
		m1   = running && tick && !crc_r[CRC_R1_CAP] && cnt_r == cr1_r;
		cap0 = running && crc_r[CRC_R0_CAP]
			&& (crc_r[CRC_R0_TRIG] ? e0_rev : e1_valid);
		cap1 = running && crc_r[CRC_R1_CAP] && e0_valid;
		ovf_set = running && tick && (&cnt_r)
			&& !(mode == MODE_CLR_EDGE && e0_valid);
		tgl = (m0 && toc_r[TOC_INV0]) ^ (m1 && toc_r[TOC_INV1])
			^ (running && tmc_r[TMC_OUT_TIME] && e0_valid);
	end

	// apb: one wait state, answer registered in the first access cycle
	always_comb begin
		idx = paddr[ADDR_W-1:2];
		acc = psel && penable && !ready_r;
		wr  = psel && penable && ready_r && pwrite && !err_r;
		hit = 1'b1;
		rdata_nxt = 32'h0;
		unique case (idx)
			IDX_PORT0_DIR: rdata_nxt[7:0] = dir_r;
			IDX_PORT0_LAT: rdata_nxt[7:0] = lat_r;
			IDX_TMC:       rdata_nxt[7:0] = tmc_r;
			IDX_PRM:       rdata_nxt[7:0] = prm_r;
			IDX_CRC:       rdata_nxt[7:0] = crc_r;
			IDX_TOC:       rdata_nxt[7:0] = toc_r & TOC_MASK;
			IDX_COUNT:     rdata_nxt[15:0] = cnt_r;
			IDX_CAPCOMP0:  rdata_nxt[15:0] = cr0_r;
			IDX_CAPCOMP1:  rdata_nxt[15:0] = cr1_r;
			default:       hit = 1'b0;
		endcase
		if (!acc || pwrite) begin
			rdata_nxt = 32'h0;
		end
		ready_nxt = acc;
		err_nxt   = acc && !hit;
	end

	always_comb begin
		dir_nxt = dir_r;
		lat_nxt = lat_r;
		prm_nxt = prm_r;
		crc_nxt = crc_r;
		toc_nxt = toc_r;
		tmc_nxt = tmc_r;
		cr0_nxt = cr0_r;
		cr1_nxt = cr1_r;
		tff_nxt = tff_r ^ tgl;
		if (wr) begin
			unique case (idx)
				IDX_PORT0_DIR: dir_nxt = pwdata[7:0];
				IDX_PORT0_LAT: lat_nxt = pwdata[7:0];
				IDX_TMC:       tmc_nxt = pwdata[7:0] & TMC_MASK;
				IDX_PRM:       prm_nxt = pwdata[7:0] & PRM_MASK;
				IDX_CRC:       crc_nxt = pwdata[7:0] & CRC_MASK;
				IDX_CAPCOMP0:  cr0_nxt = pwdata[15:0];
				IDX_CAPCOMP1:  cr1_nxt = pwdata[15:0];
				IDX_TOC: begin
					toc_nxt = pwdata[7:0] & TOC_MASK;
					// force pair beats any toggle in the same cycle
					if (pwdata[TOC_RESET] && !pwdata[TOC_SET]) begin
						tff_nxt = 1'b0;
					end else if (pwdata[TOC_SET] && !pwdata[TOC_RESET]) begin
						tff_nxt = 1'b1;
					end
				end
				default: ;
			endcase
		end
		// overflow and capture events win over a same-cycle software write
		if (ovf_set) begin
			tmc_nxt[TMC_OVF] = 1'b1;
		end
		if (cap0) begin
			cr0_nxt = cnt_r;
		end
		if (cap1) begin
			cr1_nxt = cnt_r;
		end
	end

	always_comb begin
		pre_nxt = pre_r + 1'b1;
		cnt_nxt = cnt_r;
		if (!running) begin
			cnt_nxt = '0;
		end else if (mode == MODE_CLR_EDGE && e0_valid) begin
			cnt_nxt = '0;
		end else if (tick) begin
			if (mode == MODE_CLR_MATCH && m0) begin
				cnt_nxt = '0;
			end else begin
				cnt_nxt = cnt_r + 1'b1;
			end
		end
		irq0_nxt   = m0 || cap0;
		irq1_nxt   = m1 || cap1;
		pin_nxt    = toc_r[TOC_OE] ? tff_r : lat_r[SHARED_PIN];
		pin_oe_nxt = !dir_r[SHARED_PIN];
		poe_nxt    = ~dir_r;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			dir_r    <= RST_PORT0_DIR;
			lat_r    <= RST_PORT0_LAT;
			tmc_r    <= RST_CTRL;
			prm_r    <= RST_CTRL;
			crc_r    <= RST_CTRL;
			toc_r    <= RST_CTRL;
			cnt_r    <= '0;
			cr0_r    <= '0;
			cr1_r    <= '0;
			pre_r    <= '0;
			tff_r    <= 1'b0;
			irq0_r   <= 1'b0;
			irq1_r   <= 1'b0;
			pin_r    <= 1'b0;
			pin_oe_r <= 1'b0;
			poe_r    <= 8'h00;
			rdata_r  <= 32'h0;
			ready_r  <= 1'b0;
			err_r    <= 1'b0;
		end else begin
			dir_r    <= dir_nxt;
			lat_r    <= lat_nxt;
			tmc_r    <= tmc_nxt;
			prm_r    <= prm_nxt;
			crc_r    <= crc_nxt;
			toc_r    <= toc_nxt;
			cnt_r    <= cnt_nxt;
			cr0_r    <= cr0_nxt;
			cr1_r    <= cr1_nxt;
			pre_r    <= pre_nxt;
			tff_r    <= tff_nxt;
			irq0_r   <= irq0_nxt;
			irq1_r   <= irq1_nxt;
			pin_r    <= pin_nxt;
			pin_oe_r <= pin_oe_nxt;
			poe_r    <= poe_nxt;
			rdata_r  <= rdata_nxt;
			ready_r  <= ready_nxt;
			err_r    <= err_nxt;
		end
	end

	assign prdata           = rdata_r;
	assign pready           = ready_r;
	assign pslverr          = err_r;
	assign timer_output_pin = pin_r;
	assign timer_output_oe  = pin_oe_r;
	assign port0_oe         = poe_r;
	assign match0_interrupt = irq0_r;
	assign match1_interrupt = irq1_r;

	property p_stop_zero;
		@(posedge clk) disable iff (rst)
		(mode == MODE_STOP) |=> (cnt_r == 16'h0000);
	endproperty
	a_stop_zero: assert property (p_stop_zero)
		else $error("stopped counter not held at zero");

	property p_wrap_ovf;
		@(posedge clk) disable iff (rst)
		(mode == MODE_CLR_MATCH && !crc_r[CRC_R0_CAP] && cr0_r == 16'hFFFF
			&& tick && cnt_r == 16'hFFFF) |=> (tmc_r[TMC_OVF] && cnt_r == 16'h0000);
	endproperty
	a_wrap_ovf: assert property (p_wrap_ovf)
		else $error("overflow flag not set on wrap");

	property p_interval;
		@(posedge clk) disable iff (rst)
		(mode == MODE_CLR_MATCH && !crc_r[CRC_R0_CAP] && tick && cnt_r == cr0_r)
			|=> (cnt_r == 16'h0000 && match0_interrupt);
	endproperty
	a_interval: assert property (p_interval)
		else $error("interval match did not clear count and request");

	property p_cmp1_irq;
		@(posedge clk) disable iff (rst)
		(running && tick && !crc_r[CRC_R1_CAP] && cnt_r == cr1_r) |=> match1_interrupt;
	endproperty
	a_cmp1_irq: assert property (p_cmp1_irq)
		else $error("missing match 1 request");

	property p_cap_no_cmp1;
		@(posedge clk) disable iff (rst)
		(crc_r[CRC_R1_CAP] && !e0_valid) |=> !match1_interrupt;
	endproperty
	a_cap_no_cmp1: assert property (p_cap_no_cmp1)
		else $error("register 1 compared while in capture mode");

	property p_inv0;
		@(posedge clk) disable iff (rst)
		(m0 && toc_r[TOC_INV0] && !(m1 && toc_r[TOC_INV1]) && !tmc_r[TMC_OUT_TIME]
			&& !wr) |=> (tff_r != $past(tff_r));
	endproperty
	a_inv0: assert property (p_inv0)
		else $error("output flop not inverted on match 0");

	property p_inv1;
		@(posedge clk) disable iff (rst)
		(m1 && toc_r[TOC_INV1] && !(m0 && toc_r[TOC_INV0]) && !tmc_r[TMC_OUT_TIME]
			&& !wr) |=> (tff_r != $past(tff_r));
	endproperty
	a_inv1: assert property (p_inv1)
		else $error("output flop not inverted on match 1");

	property p_force;
		@(posedge clk) disable iff (rst)
		(wr && idx == IDX_TOC && pwdata[TOC_SET +: 1] && !pwdata[TOC_RESET])
			|=> tff_r ##1 (!toc_r[TOC_OE] || timer_output_pin);
	endproperty
	a_force: assert property (p_force)
		else $error("force set did not reach output");

	property p_lvs_read;
		@(posedge clk) disable iff (rst)
		(acc && !pwrite && idx == IDX_TOC) |=> (prdata[3:2] == 2'b00 && pready);
	endproperty
	a_lvs_read: assert property (p_lvs_read)
		else $error("set/reset bits read non-zero");

	property p_div2;
		@(posedge clk) disable iff (rst)
		(prm_r[PRM_CLK_LO +: 2] == CLK_DIV2 && !wr) |=> (tick != $past(tick));
	endproperty
	a_div2: assert property (p_div2)
		else $error("divide by 2 count clock wrong");

	property p_dir_oe;
		@(posedge clk) disable iff (rst)
		1'b1 |=> (timer_output_oe == !$past(dir_r[SHARED_PIN]));
	endproperty
	a_dir_oe: assert property (p_dir_oe)
		else $error("shared pin drive does not follow direction bit");

	c_match0: cover property (@(posedge clk) disable iff (rst) match0_interrupt);
	c_cap0: cover property (@(posedge clk) disable iff (rst) cap0);
	c_ovf: cover property (@(posedge clk) disable iff (rst) ovf_set);
	c_pin: cover property (@(posedge clk) disable iff (rst) $rose(timer_output_pin));
endmodule
`default_nettype wire

// ===== ttcc_trig_filter.sv
// trigger input synchroniser and two-sample edge filter
`timescale 1ns/1ps
`default_nettype none
module ttcc_trig_filter (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic pin_in,
	input  wire logic sample,
	output logic      rise,
	output logic      fall
);
	logic sync1_r, sync2_r, samp_r, lvl_r, rise_r, fall_r;
	logic samp_nxt, lvl_nxt, rise_nxt, fall_nxt;

	always_ff @(posedge clk) begin
		if (rst) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
		end else begin
			sync1_r <= pin_in;
			sync2_r <= sync1_r;
		end
	end

	// new level must be seen on two consecutive count clock samples
	always_comb begin
		samp_nxt = samp_r;
		lvl_nxt  = lvl_r;
		rise_nxt = 1'b0;
		fall_nxt = 1'b0;
		if (sample) begin
			samp_nxt = sync2_r;
			if (sync2_r == samp_r && sync2_r != lvl_r) begin
				lvl_nxt  = sync2_r;
				rise_nxt = sync2_r;
				fall_nxt = ~sync2_r;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			samp_r <= 1'b0;
			lvl_r  <= 1'b0;
			rise_r <= 1'b0;
			fall_r <= 1'b0;
		end else begin
			samp_r <= samp_nxt;
			lvl_r  <= lvl_nxt;
			rise_r <= rise_nxt;
			fall_r <= fall_nxt;
		end
	end

	assign rise = rise_r;
	assign fall = fall_r;
endmodule
`default_nettype wire

// ===== ttcc_trig_model.sv
// far-side model: drives the two trigger pins
`timescale 1ns/1ps
`default_nettype none
module ttcc_trig_model (
	input  wire logic clk,
	output logic      trigger_input_0,
	output logic      trigger_input_1
);
	initial begin
		trigger_input_0 = 1'b0;
		trigger_input_1 = 1'b0;
	end

	// pins idle low; a pulse is a rise then a fall
	task automatic pulse(input bit which, input int len);
		@(posedge clk);
		if (which) trigger_input_1 <= 1'b1; else trigger_input_0 <= 1'b1;
		repeat (len) @(posedge clk);
		if (which) trigger_input_1 <= 1'b0; else trigger_input_0 <= 1'b0;
		repeat (len) @(posedge clk);
	endtask
endmodule
`default_nettype wire
